// ===== common/cgw_regs.svh
// constants of the per-core configuration window
`ifndef CGW_REGS_SVH
`define CGW_REGS_SVH
`define CGW_NUM_CORES 4
`define CGW_CFG_BASE 32'h1fbf_8000
`define CGW_BASE_LSB 15
`define CGW_BLK_MSB 14
`define CGW_BLK_LSB 13
`define CGW_BLK_LOCAL 2'h1
`define CGW_BLK_OTHER 2'h2
`define CGW_OFF_REDIRECT 13'h0018
`define CGW_OFF_BOOT_BASE 13'h0020
`define CGW_OFF_IDENTITY 13'h0028
`define CGW_OFF_EXT_BASE 13'h0030
`define CGW_TGT_MSB 31
`define CGW_TGT_LSB 16
`define CGW_VBASE_MSB 31
`define CGW_VBASE_LSB 12
`define CGW_EXT_ADDR_BIT 31
`define CGW_USE_RELOC_BIT 30
`define CGW_MASK_MSB 27
`define CGW_MASK_LSB 20
`define CGW_PA_MSB 3
`define CGW_PA_LSB 1
`define CGW_SEGCFG_BIT 0
`define CGW_ID_MSB 7
`define CGW_ID_LSB 0
`define CGW_DEFAULT_BOOT 32'hbfc0_0000
`define CGW_LEGACY_TOP 2'h2
`define CGW_RST_WORD 32'h0000_0000
`endif

// ===== common/cgw_pkg.sv
// types of the per-core configuration window
package cgw_pkg;
  typedef logic [1:0] cgw_core_t;
  typedef logic [12:0] cgw_off_t;
  typedef logic [31:0] cgw_word_t;
  typedef struct packed {
    logic [15:0] target;
    logic [19:0] vbase;
    logic ext;
    logic use_reloc;
    logic [7:0] mask;
    logic [2:0] pa;
    logic segcfg;
  } cgw_creg_st_t;
  typedef struct packed {
    cgw_word_t vaddr;
    cgw_word_t paddr;
  } cgw_bev_st_t;
  typedef struct packed {
    logic ack;
    logic err;
    cgw_word_t rdata;
    logic loaded;
  } cgw_top_st_t;
endpackage

// ===== common/cgw_creg_if.sv
// link between window control and one core register copy
`timescale 1ns/1ps
interface cgw_creg_if;
  import cgw_pkg::*;
  logic wr;
  cgw_off_t off;
  cgw_word_t wdata;
  cgw_word_t rdata;
  logic load;
  logic [19:0] pin_vbase;
  logic pin_ext;
  logic pin_use;
  logic [7:0] pin_mask;
  logic [2:0] pin_pa;
  cgw_creg_st_t st;
  modport bank (input wr, off, wdata, load, pin_vbase, pin_ext, pin_use, pin_mask, pin_pa,
    output rdata, st);
  modport ctl (output wr, off, wdata, load, pin_vbase, pin_ext, pin_use, pin_mask, pin_pa,
    input rdata, st);
  modport view (input st);
endinterface

// ===== rtl/cgw_core_regs.sv
// one core's copy of the local configuration registers
`timescale 1ns/1ps
`include "cgw_regs.svh"
module cgw_core_regs #(
  parameter cgw_pkg::cgw_core_t CORE_ID = 2'h0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control side
  cgw_creg_if.bank bk
);
  import cgw_pkg::*;

  cgw_creg_st_t r_reg;
  cgw_creg_st_t r_next;

  always_comb
  begin
    r_next = r_reg;
    if (bk.load)
    begin
      r_next.vbase = bk.pin_vbase;
      r_next.ext = bk.pin_ext;
      r_next.use_reloc = bk.pin_use;
      r_next.mask = bk.pin_mask;
      r_next.pa = bk.pin_pa;
      r_next.segcfg = bk.pin_ext;
    end
    else if (bk.wr)
    begin
      unique case (bk.off)
        `CGW_OFF_REDIRECT: r_next.target = bk.wdata[`CGW_TGT_MSB:`CGW_TGT_LSB];
        `CGW_OFF_BOOT_BASE: r_next.vbase = bk.wdata[`CGW_VBASE_MSB:`CGW_VBASE_LSB];
        `CGW_OFF_EXT_BASE:
        begin
          r_next.ext = bk.wdata[`CGW_EXT_ADDR_BIT];
          r_next.use_reloc = bk.wdata[`CGW_USE_RELOC_BIT];
          r_next.mask = bk.wdata[`CGW_MASK_MSB:`CGW_MASK_LSB];
          r_next.pa = bk.wdata[`CGW_PA_MSB:`CGW_PA_LSB];
          r_next.segcfg = bk.wdata[`CGW_EXT_ADDR_BIT] | bk.wdata[`CGW_SEGCFG_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // read mux
  always_comb
  begin
    bk.rdata = `CGW_RST_WORD;
    unique case (bk.off)
      `CGW_OFF_REDIRECT: bk.rdata[`CGW_TGT_MSB:`CGW_TGT_LSB] = r_reg.target;
      `CGW_OFF_BOOT_BASE: bk.rdata[`CGW_VBASE_MSB:`CGW_VBASE_LSB] = r_reg.vbase;
      `CGW_OFF_IDENTITY: bk.rdata[`CGW_ID_MSB:`CGW_ID_LSB] = 8'(CORE_ID);
      `CGW_OFF_EXT_BASE:
      begin
        bk.rdata[`CGW_EXT_ADDR_BIT] = r_reg.ext;
        bk.rdata[`CGW_USE_RELOC_BIT] = r_reg.use_reloc;
        bk.rdata[`CGW_MASK_MSB:`CGW_MASK_LSB] = r_reg.mask;
        bk.rdata[`CGW_PA_MSB:`CGW_PA_LSB] = r_reg.pa;
        bk.rdata[`CGW_SEGCFG_BIT] = r_reg.segcfg;
      end
      default: ;
    endcase
  end

  assign bk.st = r_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_cold_load;
    bk.load |=> r_reg.vbase == $past(bk.pin_vbase) && r_reg.ext == $past(bk.pin_ext);
  endproperty
  a_cold_load: assert property (p_cold_load) else $error("cold load missed");

  property p_segcfg_fixed;
    r_reg.ext |-> r_reg.segcfg;
  endproperty
  a_segcfg_fixed: assert property (p_segcfg_fixed) else $error("segment bit not fixed");
endmodule

// ===== rtl/cgw_bev_out.sv
// boot vector computation driven to one core
`timescale 1ns/1ps
`include "cgw_regs.svh"
module cgw_bev_out (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register fields
  cgw_creg_if.view fv,
  // boot vector to core
  output logic [31:0] boot_vaddr,
  output logic [31:0] boot_paddr
);
  import cgw_pkg::*;

  cgw_bev_st_t r_reg;
  cgw_bev_st_t r_next;

  always_comb
  begin
    r_next = r_reg;
    if (fv.st.segcfg)
      r_next.vaddr = {fv.st.vbase, 12'h000};
    else if (fv.st.use_reloc)
      r_next.vaddr = {`CGW_LEGACY_TOP, fv.st.vbase[17:0], 12'h000};
    else
      r_next.vaddr = `CGW_DEFAULT_BOOT;
    r_next.paddr = {fv.st.pa, r_next.vaddr[28], r_next.vaddr[27:20] & ~fv.st.mask,
      r_next.vaddr[19:12], 12'h000};
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign boot_vaddr = r_reg.vaddr;
  assign boot_paddr = r_reg.paddr;

  property p_legacy_default;
    @(posedge clk_sys) disable iff (!nrst)
    !fv.st.segcfg && !fv.st.use_reloc |=> boot_vaddr == `CGW_DEFAULT_BOOT;
  endproperty
  a_legacy_default: assert property (p_legacy_default) else $error("bad default vector");

  property p_phys_upper;
    @(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> boot_paddr[31:29] == $past(fv.st.pa);
  endproperty
  a_phys_upper: assert property (p_phys_upper) else $error("bad physical segment");
endmodule

// ===== rtl/cgw_top.sv
// per-core configuration window with redirection and boot vectors
//
// Overview of operation
// - 0x2000-0x3fff decodes requester's own block
// - 0x4000-0x5fff decodes the redirection window
// - local access reaches the requester's copy
// - space sits at fixed default base
// - redirect select register at offset 0x18
// - target number held in bits 31:16
// - window offset maps to same target offset
// - one window; own select field chooses
// - reads and writes both go redirected
// - identity register returns number of the core owning the copy
// - boot base bits 31:12 at 0x20
// - boot vectors load from pins cold only
// - boot vectors driven to each core
// - every core owns pins and registers
// - extended bit fixes segment bit high
// - relocate bit forces top bits 10 while segment bit is low
// - overlay size mask in bits 27:20
// - bits 3:1 give physical top bits
// - segment bit picks base bits used
`timescale 1ns/1ps
`include "cgw_regs.svh"
module cgw_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register request
  input wire logic req,
  input wire cgw_pkg::cgw_core_t req_core,
  input wire logic req_we,
  input wire cgw_pkg::cgw_word_t req_addr,
  input wire cgw_pkg::cgw_word_t req_wdata,
  // register answer
  output logic ack,
  output logic err,
  output cgw_pkg::cgw_word_t rdata,
  // core presence
  input wire logic [`CGW_NUM_CORES-1:0] core_present,
  // build-time boot pins per core
  input wire logic [`CGW_NUM_CORES-1:0][19:0] pin_vbase,
  input wire logic [`CGW_NUM_CORES-1:0] pin_ext,
  input wire logic [`CGW_NUM_CORES-1:0] pin_use,
  input wire logic [`CGW_NUM_CORES-1:0][7:0] pin_mask,
  input wire logic [`CGW_NUM_CORES-1:0][2:0] pin_pa,
  // boot vectors per core
  output logic [`CGW_NUM_CORES-1:0][31:0] boot_vaddr,
  output logic [`CGW_NUM_CORES-1:0][31:0] boot_paddr
);
  import cgw_pkg::*;

  localparam int NC = `CGW_NUM_CORES;
  localparam cgw_word_t CFG_BASE = `CGW_CFG_BASE;

  // ****************************************
  // decode
  // ****************************************
  cgw_top_st_t r_reg;
  cgw_top_st_t r_next;
  logic [NC-1:0][15:0] tgt_all;
  logic [NC-1:0][19:0] base_all;
  logic [NC-1:0][31:0] rdata_all;
  logic [NC-1:0][7:0] mask_all;
  logic [NC-1:0][2:0] pa_all;
  logic in_space;
  logic is_local;
  logic is_other;
  logic [15:0] tgt_num;
  logic tgt_ok;
  cgw_core_t dest;
  logic hit;

  function automatic logic core_ok(input logic [15:0] num, input logic [NC-1:0] pres);
    core_ok = (num < 16'(NC)) && pres[num[1:0]];
  endfunction

  function automatic logic known_off(input cgw_off_t o);
    known_off = (o == `CGW_OFF_REDIRECT) || (o == `CGW_OFF_BOOT_BASE) ||
      (o == `CGW_OFF_IDENTITY) || (o == `CGW_OFF_EXT_BASE);
  endfunction

  assign in_space = req_addr[31:`CGW_BASE_LSB] == CFG_BASE[31:`CGW_BASE_LSB];
  assign is_local = req_addr[`CGW_BLK_MSB:`CGW_BLK_LSB] == `CGW_BLK_LOCAL;
  assign is_other = req_addr[`CGW_BLK_MSB:`CGW_BLK_LSB] == `CGW_BLK_OTHER;
  assign tgt_num = tgt_all[req_core];
  assign tgt_ok = core_ok(tgt_num, core_present);
  assign dest = is_local ? req_core : tgt_num[1:0];
  assign hit = r_reg.loaded && req && in_space && (is_local || (is_other && tgt_ok));

  // ****************************************
  // register copies
  // ****************************************
  cgw_creg_if creg[NC] ();

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_core
      assign creg[gi].wr = hit && req_we && (dest == cgw_core_t'(gi));
      assign creg[gi].off = req_addr[12:0];
      assign creg[gi].wdata = req_wdata;
      assign creg[gi].load = !r_reg.loaded;
      assign creg[gi].pin_vbase = pin_vbase[gi];
      assign creg[gi].pin_ext = pin_ext[gi];
      assign creg[gi].pin_use = pin_use[gi];
      assign creg[gi].pin_mask = pin_mask[gi];
      assign creg[gi].pin_pa = pin_pa[gi];
      assign tgt_all[gi] = creg[gi].st.target;
      assign base_all[gi] = creg[gi].st.vbase;
      assign rdata_all[gi] = creg[gi].rdata;
      assign mask_all[gi] = creg[gi].st.mask;
      assign pa_all[gi] = creg[gi].st.pa;
      cgw_core_regs #(
        .CORE_ID(cgw_core_t'(gi))
      ) u_regs (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .bk(creg[gi])
      );
      cgw_bev_out u_bev (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .fv(creg[gi]),
        .boot_vaddr(boot_vaddr[gi]),
        .boot_paddr(boot_paddr[gi])
      );
    end
  endgenerate

  // ****************************************
  // answer
  // ****************************************
  always_comb
  begin
    r_next = r_reg;
    r_next.loaded = 1'b1;
    r_next.ack = req;
    r_next.err = req && (!r_reg.loaded || !in_space || !(is_local || is_other));
    r_next.rdata = `CGW_RST_WORD;
    if (hit && !req_we)
      r_next.rdata = rdata_all[dest];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign ack = r_reg.ack;
  assign err = r_reg.err;
  assign rdata = r_reg.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_local(logic [12:0] o);
    r_reg.loaded && req && in_space && is_local && req_addr[12:0] == o;
  endsequence

  sequence s_other(logic [12:0] o);
    r_reg.loaded && req && in_space && is_other && req_addr[12:0] == o;
  endsequence

  property p_ack_next;
    req |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no answer");

  property p_outside_err;
    req && !in_space |=> err && rdata == `CGW_RST_WORD;
  endproperty
  a_outside_err: assert property (p_outside_err) else $error("outside space not refused");

  property p_local_sel_wr;
    s_local(`CGW_OFF_REDIRECT) and req_we
      |=> tgt_all[$past(req_core)] == $past(req_wdata[31:16]);
  endproperty
  a_local_sel_wr: assert property (p_local_sel_wr) else $error("select not stored");

  property p_local_sel_rd;
    s_local(`CGW_OFF_REDIRECT) and !req_we
      |=> rdata[31:16] == $past(tgt_all[req_core]) && rdata[15:0] == 16'h0000;
  endproperty
  a_local_sel_rd: assert property (p_local_sel_rd) else $error("select readback wrong");

  property p_identity;
    s_local(`CGW_OFF_IDENTITY) and !req_we |=> rdata[7:0] == 8'($past(req_core));
  endproperty
  a_identity: assert property (p_identity) else $error("identity wrong");

  property p_redirect_wr;
    s_other(`CGW_OFF_BOOT_BASE) and req_we && tgt_ok
      |=> base_all[$past(dest)] == $past(req_wdata[31:12]);
  endproperty
  a_redirect_wr: assert property (p_redirect_wr) else $error("redirected write lost");

  property p_absent_rd;
    r_reg.loaded && req && in_space && is_other && !tgt_ok |=> rdata == `CGW_RST_WORD;
  endproperty
  a_absent_rd: assert property (p_absent_rd) else $error("absent target read not zero");

  property p_local_base_wr;
    s_local(`CGW_OFF_BOOT_BASE) and req_we
      |=> base_all[$past(req_core)] == $past(req_wdata[31:12]);
  endproperty
  a_local_base_wr: assert property (p_local_base_wr) else $error("local write missed");

  property p_ack_only;
    ack |-> $past(req);
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("stray ack");

  property p_no_req_quiet;
    !req |=> !ack && !err && rdata == `CGW_RST_WORD;
  endproperty
  a_no_req_quiet: assert property (p_no_req_quiet) else $error("idle not quiet");

  property p_bad_block_err;
    req && in_space && !is_local && !is_other |=> err;
  endproperty
  a_bad_block_err: assert property (p_bad_block_err) else $error("bad block not refused");

  property p_local_no_err;
    r_reg.loaded && req && in_space && is_local |=> !err;
  endproperty
  a_local_no_err: assert property (p_local_no_err) else $error("local refused");

  property p_other_no_err;
    r_reg.loaded && req && in_space && is_other |=> !err;
  endproperty
  a_other_no_err: assert property (p_other_no_err) else $error("window refused");

  property p_write_rd_zero;
    req && req_we |=> rdata == `CGW_RST_WORD;
  endproperty
  a_write_rd_zero: assert property (p_write_rd_zero) else $error("write returned data");

  property p_redirect_rd;
    s_other(`CGW_OFF_BOOT_BASE) and !req_we && tgt_ok
      |=> rdata == {$past(base_all[dest]), 12'h000};
  endproperty
  a_redirect_rd: assert property (p_redirect_rd) else $error("redirected read wrong");

  property p_redirect_id;
    s_other(`CGW_OFF_IDENTITY) and !req_we && tgt_ok |=> rdata[7:0] == 8'($past(tgt_num));
  endproperty
  a_redirect_id: assert property (p_redirect_id) else $error("window identity wrong");

  property p_absent_wr;
    s_other(`CGW_OFF_BOOT_BASE) and req_we && !tgt_ok |=> $stable(base_all);
  endproperty
  a_absent_wr: assert property (p_absent_wr) else $error("absent write landed");

  property p_outside_stable;
    r_reg.loaded && req && !in_space |=> $stable(base_all) && $stable(tgt_all);
  endproperty
  a_outside_stable: assert property (p_outside_stable) else $error("outside access wrote");

  property p_unmapped_zero;
    hit && !req_we && !known_off(req_addr[12:0]) |=> rdata == `CGW_RST_WORD;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_ext_rd;
    s_local(`CGW_OFF_EXT_BASE) and !req_we
      |=> rdata[`CGW_MASK_MSB:`CGW_MASK_LSB] == $past(mask_all[req_core])
      && rdata[`CGW_PA_MSB:`CGW_PA_LSB] == $past(pa_all[req_core]);
  endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("ext base readback wrong");

  property p_segbit_rd;
    s_local(`CGW_OFF_EXT_BASE) and !req_we
      |=> !rdata[`CGW_EXT_ADDR_BIT] || rdata[`CGW_SEGCFG_BIT];
  endproperty
  a_segbit_rd: assert property (p_segbit_rd) else $error("segment bit readback");

  property p_base_rd;
    s_local(`CGW_OFF_BOOT_BASE) and !req_we
      |=> rdata == {$past(base_all[req_core]), 12'h000};
  endproperty
  a_base_rd: assert property (p_base_rd) else $error("base readback wrong");

  property p_loaded_stays;
    r_reg.loaded |=> r_reg.loaded;
  endproperty
  a_loaded_stays: assert property (p_loaded_stays) else $error("reloaded without reset");

  property p_sel_keeps_base;
    s_local(`CGW_OFF_REDIRECT) and req_we |=> $stable(base_all);
  endproperty
  a_sel_keeps_base: assert property (p_sel_keeps_base) else $error("select write hit base");
endmodule

// ===== sim/cgw_core_bfm.sv
// processor core model issuing register accesses
`timescale 1ns/1ps
module cgw_core_bfm (
  // clock
  input wire logic clk_sys,
  // request
  output logic req,
  output cgw_pkg::cgw_core_t req_core,
  output logic req_we,
  output cgw_pkg::cgw_word_t req_addr,
  output cgw_pkg::cgw_word_t req_wdata,
  // answer
  input wire logic ack,
  input wire logic err,
  input wire cgw_pkg::cgw_word_t rdata
);
  import cgw_pkg::*;
  initial
  begin
    req = 1'h0;
    req_core = 2'h0;
    req_we = 1'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
  end
  // ****
  // one access, taken at next edge, answer sampled mid-cycle while it stands
  // ****
  task automatic xfer(input cgw_core_t c, input logic we, input cgw_word_t a,
    input cgw_word_t d, output logic k, output logic e, output cgw_word_t q);
    @(posedge clk_sys);
    #1;
    req = 1'h1;
    req_core = c;
    req_we = we;
    req_addr = a;
    req_wdata = d;
    @(posedge clk_sys);
    #1;
    req = 1'h0;
    // released lines show no stale value
    req_addr = ~a;
    req_wdata = ~d;
    @(negedge clk_sys);
    k = ack;
    e = err;
    q = rdata;
    @(posedge clk_sys);
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench of the configuration window
`timescale 1ns/1ps
`include "cgw_regs.svh"
module tb_top;
  import cgw_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
  logic clk_sys, nrst, req, req_we, ack, err;
  cgw_core_t req_core;
  cgw_word_t req_addr, req_wdata, rdata;
  logic [3:0] core_present, pin_ext, pin_use;
  logic [3:0][19:0] pin_vbase;
  logic [3:0][7:0] pin_mask;
  logic [3:0][2:0] pin_pa;
  logic [3:0][31:0] boot_vaddr, boot_paddr;
  int err_total, checks_done;
  cgw_top uut (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_core(req_core),
    .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata), .ack(ack), .err(err),
    .rdata(rdata), .core_present(core_present), .pin_vbase(pin_vbase), .pin_ext(pin_ext),
    .pin_use(pin_use), .pin_mask(pin_mask), .pin_pa(pin_pa), .boot_vaddr(boot_vaddr),
    .boot_paddr(boot_paddr));
  cgw_core_bfm bfm (.clk_sys(clk_sys), .req(req), .req_core(req_core), .req_we(req_we),
    .req_addr(req_addr), .req_wdata(req_wdata), .ack(ack), .err(err), .rdata(rdata));
  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ****
  // helpers
  // ****
  function automatic cgw_word_t vexp(logic s, logic u, logic [19:0] b);
    return s ? {b, 12'h0} : (u ? {`CGW_LEGACY_TOP, b[17:0], 12'h0} : `CGW_DEFAULT_BOOT);
  endfunction
  function automatic cgw_word_t pexp(cgw_word_t v, logic [7:0] m, logic [2:0] pa);
    return {pa, v[28], v[27:20] & ~m, v[19:12], 12'h0};
  endfunction
  task automatic rchk(input int c, input cgw_word_t off, input cgw_word_t ex, input logic ee);
    logic k, e;
    cgw_word_t q;
    bfm.xfer(cgw_core_t'(c), 1'h0, `CGW_CFG_BASE + off, 32'h0, k, e, q);
    `CHK("ack", 1'h1, k)
    `CHK("err", ee, e)
    `CHK("rdata", ex, q)
  endtask
  task automatic wr(input int c, input cgw_word_t off, input cgw_word_t d);
    logic k, e;
    cgw_word_t q;
    bfm.xfer(cgw_core_t'(c), 1'h1, `CGW_CFG_BASE + off, d, k, e, q);
    `CHK("wr_ack", 1'h1, k)
    `CHK("wr_err", 1'h0, e)
  endtask
  task automatic do_reset();
    #1;
    nrst = 1'h0;
    repeat (16) @(posedge clk_sys);
    #1;
    nrst = 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_boot();
    cgw_word_t v;
    cgw_word_t x;
    for (int c = 0; c < 4; c++)
    begin
      v = vexp(pin_ext[c], pin_use[c], pin_vbase[c]);
      `CHK("boot_vaddr", v, boot_vaddr[c])
      `CHK("boot_paddr", pexp(v, pin_mask[c], pin_pa[c]), boot_paddr[c])
      rchk(c, 32'h2020, {pin_vbase[c], 12'h0}, 1'h0);
      x = {pin_ext[c], pin_use[c], 2'h0, pin_mask[c], 16'h0, pin_pa[c], pin_ext[c]};
      rchk(c, 32'h2030, x, 1'h0);
      rchk(c, 32'h2028, {30'h0, cgw_core_t'(c)}, 1'h0);
    end
    $display("test boot done");
  endtask
  task automatic t_local();
    wr(0, 32'h2020, 32'h1234_5fff);
    wr(1, 32'h2020, 32'h0abc_d000);
    rchk(0, 32'h2020, 32'h1234_5000, 1'h0);
    rchk(1, 32'h2020, 32'h0abc_d000, 1'h0);
    `CHK("boot_vaddr", 32'h1234_5000, boot_vaddr[0])
    `CHK("boot_vaddr", vexp(1'h0, 1'h1, 20'h0abcd), boot_vaddr[1])
    rchk(0, 32'h2040, 32'h0, 1'h0);
    $display("test local done");
  endtask
  task automatic t_redirect();
    wr(0, 32'h2018, 32'h0001_0000);
    rchk(0, 32'h2018, 32'h0001_0000, 1'h0);
    wr(0, 32'h4020, 32'h7777_7000);
    rchk(1, 32'h2020, 32'h7777_7000, 1'h0);
    rchk(0, 32'h2020, 32'h1234_5000, 1'h0);
    rchk(0, 32'h4020, 32'h7777_7000, 1'h0);
    rchk(0, 32'h4028, 32'h1, 1'h0);
    wr(2, 32'h2018, 32'h0003_0000);
    rchk(2, 32'h4028, 32'h3, 1'h0);
    rchk(0, 32'h4028, 32'h1, 1'h0);
    $display("test redirect done");
  endtask
  task automatic t_absent();
    #1;
    core_present = 4'h7;
    wr(2, 32'h4020, 32'h5555_5000);
    rchk(2, 32'h4020, 32'h0, 1'h0);
    #1;
    core_present = 4'hf;
    rchk(3, 32'h2020, {pin_vbase[3], 12'h0}, 1'h0);
    wr(2, 32'h2018, 32'h0005_0000);
    rchk(2, 32'h4020, 32'h0, 1'h0);
    $display("test absent done");
  endtask
  task automatic t_errors();
    rchk(0, 32'h8020, 32'h0, 1'h1);
    rchk(0, 32'hf000_2020, 32'h0, 1'h1);
    rchk(0, 32'h0018, 32'h0, 1'h1);
    rchk(0, 32'h6020, 32'h0, 1'h1);
    rchk(1, 32'h4040, 32'h0, 1'h0);
    $display("test errors done");
  endtask
  task automatic t_ext();
    cgw_word_t w[4] = '{32'h4300_0009, 32'hc300_0008, 32'h4300_0008, 32'h0300_0008};
    cgw_word_t r[4] = '{32'h4300_0009, 32'hc300_0009, 32'h4300_0008, 32'h0300_0008};
    cgw_word_t v;
    for (int i = 0; i < 4; i++)
    begin
      wr(2, 32'h2030, w[i]);
      rchk(2, 32'h2030, r[i], 1'h0);
      v = vexp(r[i][0], r[i][30], pin_vbase[2]);
      `CHK("boot_vaddr", v, boot_vaddr[2])
      `CHK("boot_paddr", pexp(v, 8'h30, 3'h4), boot_paddr[2])
    end
    $display("test ext done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // main sequence and watchdog
  // ****
  initial
  begin
    err_total = 0;
    checks_done = 0;
    nrst = 1'h0;
    core_present = 4'hf;
    pin_vbase = {20'h5a5a5, 20'habcde, 20'h12345, 20'h9fc10};
    pin_ext = 4'h9;
    pin_use = 4'ha;
    pin_mask = {8'hff, 8'h01, 8'hf0, 8'h0f};
    pin_pa = {3'h0, 3'h7, 3'h2, 3'h5};
    do_reset();
    t_boot();
    t_local();
    t_redirect();
    t_absent();
    t_errors();
    t_ext();
    // second cold reset reloads from pins
    do_reset();
    t_boot();
    complete_run();
  end
  // about 200 cycles expected, cut off at 2000
  initial
  begin
    #80000;
    err_total++;
    complete_run();
  end
endmodule
